// *** hdl/iosa_twi_regs.sv ***
// Overview of operation
// - set and clear bit forms act only on I/O addresses 0x00 to 0x1F.
// - skip-if-set and skip-if-clear forms get one selected bit of low registers.
// - some status flags clear on writing one; writing zero leaves them alone.
// - bit set or clear touches only the addressed bit, no write-back of others.
// - data-space address of an I/O register is its I/O address plus 0x20.
// - extended region 0x60 to 0xFF answers only load and store forms.
// - control at 0xBC: event, ack, start, stop, collision, enable, reserved, irq enable.
// - data register at 0xBB holds the byte sent or received on the bus.
// - own address at 0xBA: seven-bit address in 7:1, general call in 0.
// - status at 0xB9: code in 7:3, reserved 2, prescaler select in 1:0.
// - bit-rate register at 0xB8 holds the eight-bit serial clock divider.
`timescale 1ns/1ns
module iosa_twi_regs
  import iosa_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // core access
  input  wire logic        i_acc_valid,
  input  iosa_kind_t       i_acc_kind,
  input  wire logic [15:0] i_acc_addr,
  input  wire logic [2:0]  i_acc_bit,
  input  wire logic [7:0]  i_acc_wdata,
  output logic             o_acc_done_q,
  output logic             o_acc_err_q,
  output logic [7:0]       o_acc_rdata_q,
  output logic             o_acc_bit_q,
  output logic             o_acc_skip_q,
  // forwarded I/O bus to other peripherals
  output logic             o_io_req_q,
  output logic             o_io_we_q,
  output logic [7:0]       o_io_addr_q,
  output logic [7:0]       o_io_wdata_q,
  output logic [7:0]       o_io_wmask_q,
  input  wire logic [7:0]  i_io_rdata,
  // events from the bus engine
  input  wire logic        i_evt_set,
  input  wire logic        i_wcol_set,
  input  wire logic        i_stop_done,
  input  wire logic        i_state_we,
  input  wire logic [4:0]  i_state_code,
  input  wire logic        i_rx_we,
  input  wire logic [7:0]  i_rx_data,
  // settings to the bus engine
  output logic             o_evt_flag_q,
  output logic             o_ack_en_q,
  output logic             o_start_req_q,
  output logic             o_stop_req_q,
  output logic             o_wcol_flag_q,
  output logic             o_iface_en_q,
  output logic             o_irq_en_q,
  output logic [6:0]       o_own_addr_q,
  output logic             o_gc_accept_q,
  output logic [1:0]       o_prescale_q,
  output logic [7:0]       o_bitrate_q,
  output logic [7:0]       o_tx_data_q
);
  iosa_dec_if dec_if ();

  iosa_decode u_decode (
    .i_valid (i_acc_valid),
    .i_kind  (i_acc_kind),
    .i_addr  (i_acc_addr),
    .i_bit   (i_acc_bit),
    .i_wdata (i_acc_wdata),
    .o_req   (dec_if.dec)
  );

  // stage one: registered request
  logic       s1_valid_q, s1_err_q, s1_rd_q, s1_wr_q, s1_sks_q, s1_skc_q, s1_twi_q;
  logic [7:0] s1_addr_q, s1_wdata_q, s1_wmask_q;
  logic [2:0] s1_bit_q;
  logic       s1_valid_d, s1_err_d, s1_rd_d, s1_wr_d, s1_sks_d, s1_skc_d, s1_twi_d;
  logic [7:0] s1_addr_d, s1_wdata_d, s1_wmask_d;
  logic [2:0] s1_bit_d;
  logic       io_req_d, io_we_d;

  // forward only legal accesses outside the serial group
  always_comb begin
    s1_valid_d = dec_if.valid;
    s1_err_d   = dec_if.err;
    s1_rd_d    = dec_if.rd;
    s1_wr_d    = dec_if.wr;
    s1_sks_d   = dec_if.skip_set;
    s1_skc_d   = dec_if.skip_clr;
    s1_twi_d   = dec_if.twi_grp && dec_if.ldst;
    s1_addr_d  = dec_if.daddr;
    s1_wdata_d = dec_if.wdata;
    s1_wmask_d = dec_if.wmask;
    s1_bit_d   = dec_if.bit_idx;
    io_req_d   = dec_if.valid && !dec_if.err && !dec_if.twi_grp;
    io_we_d    = io_req_d && dec_if.wr;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_valid_q   <= 1'b0;
      s1_err_q     <= 1'b0;
      s1_rd_q      <= 1'b0;
      s1_wr_q      <= 1'b0;
      s1_sks_q     <= 1'b0;
      s1_skc_q     <= 1'b0;
      s1_twi_q     <= 1'b0;
      s1_addr_q    <= 8'h00;
      s1_wdata_q   <= 8'h00;
      s1_wmask_q   <= 8'h00;
      s1_bit_q     <= 3'h0;
      o_io_req_q   <= 1'b0;
      o_io_we_q    <= 1'b0;
    end else begin
      s1_valid_q   <= s1_valid_d;
      s1_err_q     <= s1_err_d;
      s1_rd_q      <= s1_rd_d;
      s1_wr_q      <= s1_wr_d;
      s1_sks_q     <= s1_sks_d;
      s1_skc_q     <= s1_skc_d;
      s1_twi_q     <= s1_twi_d;
      s1_addr_q    <= s1_addr_d;
      s1_wdata_q   <= s1_wdata_d;
      s1_wmask_q   <= s1_wmask_d;
      s1_bit_q     <= s1_bit_d;
      o_io_req_q   <= io_req_d;
      o_io_we_q    <= io_we_d;
    end
  end

  // bus fields mirror the request register
  assign o_io_addr_q  = s1_addr_q;
  assign o_io_wdata_q = s1_wdata_q;
  assign o_io_wmask_q = s1_wmask_q;

  // serial register state
  logic [7:0] ctrl_q, data_q, own_q, rate_q, ctrl_d, data_d, own_d, rate_d;
  logic [4:0] code_q, code_d;
  logic [1:0] ps_q, ps_d;
  logic       twi_ok, w_ctrl, w_data, w_own, w_state, w_rate;
  logic [7:0] wr_ctrl_val;

  always_comb begin
    twi_ok      = s1_valid_q && !s1_err_q && s1_twi_q;
    w_ctrl      = twi_ok && s1_wr_q && (s1_addr_q == ADR_CTRL);
    w_data      = twi_ok && s1_wr_q && (s1_addr_q == ADR_DATA);
    w_own       = twi_ok && s1_wr_q && (s1_addr_q == ADR_OWNADR);
    w_state     = twi_ok && s1_wr_q && (s1_addr_q == ADR_STATE);
    w_rate      = twi_ok && s1_wr_q && (s1_addr_q == ADR_BITRATE);
    wr_ctrl_val = (ctrl_q & ~s1_wmask_q) | (s1_wdata_q & s1_wmask_q);
    // plain control bits follow the write, reserved bit 1 stays zero
    ctrl_d = w_ctrl ? ((ctrl_q & ~CTRL_RW_MSK) | (wr_ctrl_val & CTRL_RW_MSK)) : ctrl_q;
    // engine ends a stop condition unless software writes control now
    if (i_stop_done && !w_ctrl) begin
      ctrl_d[CB_STO] = 1'b0;
    end
    // event flag: writing one clears, zero holds, a new event wins
    if (w_ctrl && s1_wdata_q[CB_EVT] && s1_wmask_q[CB_EVT]) begin
      ctrl_d[CB_EVT] = 1'b0;
    end
    if (i_evt_set) begin
      ctrl_d[CB_EVT] = 1'b1;
    end
    // collision flag clears on a data write while the event flag is up
    if (w_data && ctrl_q[CB_EVT]) begin
      ctrl_d[CB_WCOL] = 1'b0;
    end
    if (i_wcol_set) begin
      ctrl_d[CB_WCOL] = 1'b1;
    end
    ctrl_d[1] = 1'b0;
    // received byte wins over a software write in the same cycle
    data_d = i_rx_we ? i_rx_data : (w_data ? s1_wdata_q : data_q);
    own_d  = w_own ? s1_wdata_q : own_q;
    rate_d = w_rate ? s1_wdata_q : rate_q;
    ps_d   = w_state ? s1_wdata_q[SB_PS_LSB +: 2] : ps_q;
    code_d = i_state_we ? i_state_code : code_q;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= RST_CTRL;
      data_q <= RST_DATA;
      own_q  <= RST_OWNADR;
      rate_q <= RST_BITRATE;
      code_q <= RST_CODE;
      ps_q   <= RST_PS;
    end else begin
      ctrl_q <= ctrl_d;
      data_q <= data_d;
      own_q  <= own_d;
      rate_q <= rate_d;
      code_q <= code_d;
      ps_q   <= ps_d;
    end
  end

  // engine-facing views of the registers
  assign o_evt_flag_q  = ctrl_q[CB_EVT];
  assign o_ack_en_q    = ctrl_q[CB_ACK];
  assign o_start_req_q = ctrl_q[CB_STA];
  assign o_stop_req_q  = ctrl_q[CB_STO];
  assign o_wcol_flag_q = ctrl_q[CB_WCOL];
  assign o_iface_en_q  = ctrl_q[CB_EN];
  assign o_irq_en_q    = ctrl_q[CB_IE];
  assign o_own_addr_q  = own_q[OA_ADR_LSB +: 7];
  assign o_gc_accept_q = own_q[OA_GC];
  assign o_prescale_q  = ps_q;
  assign o_bitrate_q   = rate_q;
  assign o_tx_data_q   = data_q;

  // stage two: answer to the core
  logic [7:0] twi_rd, rd_d;
  logic       done_d, err_d, bit_d, skip_d;

  always_comb begin
    unique case (s1_addr_q)
      ADR_BITRATE: twi_rd = rate_q;
      ADR_STATE:   twi_rd = {code_q, 1'b0, ps_q};
      ADR_OWNADR:  twi_rd = own_q;
      ADR_DATA:    twi_rd = data_q;
      ADR_CTRL:    twi_rd = ctrl_q;
      default:     twi_rd = 8'h00;
    endcase
    done_d = s1_valid_q;
    err_d  = s1_valid_q && s1_err_q;
    // errored or write accesses return zero data
    rd_d   = 8'h00;
    if (s1_valid_q && !s1_err_q && s1_rd_q) begin
      rd_d = s1_twi_q ? twi_rd : i_io_rdata;
    end
    bit_d  = rd_d[s1_bit_q];
    // refused or idle cycles never report a skip, whatever kind lingers
    skip_d = s1_valid_q && !s1_err_q && ((s1_sks_q && bit_d) || (s1_skc_q && !bit_d));
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_acc_done_q  <= 1'b0;
      o_acc_err_q   <= 1'b0;
      o_acc_rdata_q <= 8'h00;
      o_acc_bit_q   <= 1'b0;
      o_acc_skip_q  <= 1'b0;
    end else begin
      o_acc_done_q  <= done_d;
      o_acc_err_q   <= err_d;
      o_acc_rdata_q <= rd_d;
      o_acc_bit_q   <= bit_d;
      o_acc_skip_q  <= skip_d;
    end
  end

  // checks on the decoder and the register group
  a_bit_range_err: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_acc_valid && (i_acc_kind == KIND_SET_BIT || i_acc_kind == KIND_CLR_BIT) && i_acc_addr > IO_BIT_MAX)
      |-> ##2 (o_acc_done_q && o_acc_err_q))
    else $error("bit form above low range not refused");

  a_skip_bit_sel: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_acc_valid && i_acc_kind == KIND_SKIP_CLR && i_acc_addr <= IO_BIT_MAX)
      |-> ##2 (o_acc_skip_q == !o_acc_bit_q) && (o_acc_bit_q == o_acc_rdata_q[$past(i_acc_bit, 2)]))
    else $error("skip result does not follow selected bit");

  a_evt_w1c_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (w_ctrl && s1_wdata_q[CB_EVT] && !i_evt_set) |=> !o_evt_flag_q)
    else $error("event flag not cleared by writing one");

  a_evt_zero_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (w_ctrl && !s1_wdata_q[CB_EVT]) |=> (o_evt_flag_q == ($past(o_evt_flag_q) || $past(i_evt_set))))
    else $error("writing zero changed the event flag");

  a_bit_one_lane: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_acc_valid && (i_acc_kind == KIND_SET_BIT || i_acc_kind == KIND_CLR_BIT) && i_acc_addr <= IO_BIT_MAX)
      |=> (o_io_req_q && o_io_we_q && $onehot(o_io_wmask_q) && o_io_wmask_q[$past(i_acc_bit)]))
    else $error("bit form wrote more than one lane");

  a_port_ds_ofs: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_acc_valid && i_acc_kind == KIND_PORT_WRITE && i_acc_addr <= IO_PORT_MAX)
      |=> (o_io_req_q && o_io_addr_q == 8'($past(i_acc_addr) + IO_DS_OFS)))
    else $error("port address not offset into data space");

  a_ext_ldst_only: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_acc_valid && !(i_acc_kind == KIND_LOAD || i_acc_kind == KIND_STORE))
      |=> !(o_io_req_q && o_io_addr_q >= EXT_LO) && !twi_ok)
    else $error("extended region reached by port or bit form");

  a_ctrl_layout: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (w_ctrl && !i_stop_done)
      |=> (o_ack_en_q == $past(s1_wdata_q[CB_ACK])) && (o_stop_req_q == $past(s1_wdata_q[CB_STO]))
          && (o_irq_en_q == $past(s1_wdata_q[CB_IE])) && !ctrl_q[1])
    else $error("control write landed in wrong bits");

  a_data_store: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (w_data && !i_rx_we) |=> (o_tx_data_q == $past(s1_wdata_q)))
    else $error("data register did not take the store");

  a_own_fields: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    w_own |=> (o_own_addr_q == $past(s1_wdata_q[7:1])) && (o_gc_accept_q == $past(s1_wdata_q[0])))
    else $error("own address fields misplaced");

  a_state_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (twi_ok && s1_rd_q && s1_addr_q == ADR_STATE)
      |=> (o_acc_rdata_q[7:3] == $past(code_q)) && !o_acc_rdata_q[2] && (o_acc_rdata_q[1:0] == $past(ps_q)))
    else $error("status read layout wrong");

  a_rate_store: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    w_rate |=> ##1 (o_bitrate_q == $past(s1_wdata_q, 2)))
    else $error("bit-rate register lost its value");

  a_rsv_read_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (twi_ok && s1_rd_q && (s1_addr_q == GRP_LO || s1_addr_q > ADR_CTRL)) |=> (o_acc_rdata_q == 8'h00))
    else $error("reserved address read nonzero");
endmodule

// *** pkg/iosa_pkg.sv ***
package iosa_pkg;
  // address space limits, core view
  localparam logic [15:0] IO_BIT_MAX  = 16'h001f;
  localparam logic [15:0] IO_PORT_MAX = 16'h003f;
  localparam logic [15:0] IO_DS_OFS   = 16'h0020;
  localparam logic [15:0] IO_DS_HI    = 16'h00ff;
  localparam logic [7:0]  EXT_LO      = 8'h60;
  // serial register group, data-space addresses
  localparam logic [7:0]  GRP_LO      = 8'hb7;
  localparam logic [7:0]  ADR_BITRATE = 8'hb8;
  localparam logic [7:0]  ADR_STATE   = 8'hb9;
  localparam logic [7:0]  ADR_OWNADR  = 8'hba;
  localparam logic [7:0]  ADR_DATA    = 8'hbb;
  localparam logic [7:0]  ADR_CTRL    = 8'hbc;
  localparam logic [7:0]  GRP_HI      = 8'hbf;
  // serial_ctrl_reg bit positions
  localparam int          CB_EVT      = 7;
  localparam int          CB_ACK      = 6;
  localparam int          CB_STA      = 5;
  localparam int          CB_STO      = 4;
  localparam int          CB_WCOL     = 3;
  localparam int          CB_EN       = 2;
  localparam int          CB_IE       = 0;
  localparam logic [7:0]  CTRL_RW_MSK = 8'h75;
  // serial_state_reg and own_address_reg fields
  localparam int          SB_CODE_LSB = 3;
  localparam int          SB_PS_LSB   = 0;
  localparam int          OA_ADR_LSB  = 1;
  localparam int          OA_GC       = 0;
  // reset values
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [7:0]  RST_DATA    = 8'h00;
  localparam logic [7:0]  RST_OWNADR  = 8'h00;
  localparam logic [4:0]  RST_CODE    = 5'h00;
  localparam logic [1:0]  RST_PS      = 2'h0;
  localparam logic [7:0]  RST_BITRATE = 8'h00;

  // instruction forms the core issues
  typedef enum logic [2:0] {
    KIND_PORT_READ  = 3'h0,
    KIND_PORT_WRITE = 3'h1,
    KIND_LOAD       = 3'h2,
    KIND_STORE      = 3'h3,
    KIND_SET_BIT    = 3'h4,
    KIND_CLR_BIT    = 3'h5,
    KIND_SKIP_SET   = 3'h6,
    KIND_SKIP_CLR   = 3'h7
  } iosa_kind_t;
endpackage

// *** pkg/iosa_dec_if.sv ***
`timescale 1ns/1ns
interface iosa_dec_if;
  logic       valid;
  logic       err;
  logic       rd;
  logic       wr;
  logic       skip_set;
  logic       skip_clr;
  logic       twi_grp;
  logic [7:0] daddr;
  logic [2:0] bit_idx;
  logic [7:0] wdata;
  logic [7:0] wmask;
  logic       ldst;

  modport dec  (output valid, err, rd, wr, skip_set, skip_clr, twi_grp, daddr, bit_idx, wdata, wmask, ldst);
  modport bank (input  valid, err, rd, wr, skip_set, skip_clr, twi_grp, daddr, bit_idx, wdata, wmask, ldst);
endinterface

// *** hdl/iosa_decode.sv ***
`timescale 1ns/1ns
module iosa_decode
  import iosa_pkg::*;
(
  // core access
  input  wire logic       i_valid,
  input  iosa_kind_t      i_kind,
  input  wire logic [15:0] i_addr,
  input  wire logic [2:0] i_bit,
  input  wire logic [7:0] i_wdata,
  // decoded request
  iosa_dec_if.dec         o_req
);
  logic [15:0] daddr;
  logic        ok;
  logic        is_port;
  logic        is_bit;
  logic        is_ldst;

  // classify the form, range check and map to data space
  always_comb begin
    is_port = (i_kind == KIND_PORT_READ) || (i_kind == KIND_PORT_WRITE);
    is_ldst = (i_kind == KIND_LOAD) || (i_kind == KIND_STORE);
    is_bit  = !is_port && !is_ldst;
    daddr   = i_addr;
    ok      = 1'b0;
    if (is_port) begin
      ok    = (i_addr <= IO_PORT_MAX);
      daddr = i_addr + IO_DS_OFS;
    end else if (is_bit) begin
      ok    = (i_addr <= IO_BIT_MAX);
      daddr = i_addr + IO_DS_OFS;
    end else begin
      ok    = (i_addr >= IO_DS_OFS) && (i_addr <= IO_DS_HI);
    end
    // extended region is never reached by port or bit forms
    if (!is_ldst && (daddr[7:0] >= EXT_LO)) begin
      ok = 1'b0;
    end
  end

  // single-bit forms write one bit lane only, so w1c neighbours survive
  always_comb begin
    o_req.valid    = i_valid;
    o_req.err      = i_valid && !ok;
    o_req.ldst     = is_ldst;
    o_req.daddr    = daddr[7:0];
    o_req.bit_idx  = i_bit;
    o_req.twi_grp  = (daddr[7:0] >= GRP_LO) && (daddr[7:0] <= GRP_HI);
    o_req.rd       = (i_kind == KIND_PORT_READ) || (i_kind == KIND_LOAD) ||
                     (i_kind == KIND_SKIP_SET) || (i_kind == KIND_SKIP_CLR);
    o_req.wr       = (i_kind == KIND_PORT_WRITE) || (i_kind == KIND_STORE) ||
                     (i_kind == KIND_SET_BIT) || (i_kind == KIND_CLR_BIT);
    o_req.skip_set = (i_kind == KIND_SKIP_SET);
    o_req.skip_clr = (i_kind == KIND_SKIP_CLR);
    if (i_kind == KIND_SET_BIT || i_kind == KIND_CLR_BIT) begin
      o_req.wmask = 8'h01 << i_bit;
      o_req.wdata = (i_kind == KIND_SET_BIT) ? 8'hff : 8'h00;
    end else begin
      o_req.wmask = 8'hff;
      o_req.wdata = i_wdata;
    end
  end
endmodule

// *** dv/iosa_periph_model.sv ***
`timescale 1ns/1ns
module iosa_periph_model (
  // forwarded i/o bus from the decoder
  input  wire logic       i_mclk,
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_wmask,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [256];
  logic [7:0] idle_pat = 8'h5a;

  // known start contents, mirrored by the bench
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);

  // only masked lanes change, so flags beside the target bit survive
  always @(posedge i_mclk) begin
    idle_pat <= idle_pat + 8'h3b;
    if (i_req && i_we) begin
      mem[i_addr] <= (mem[i_addr] & ~i_wmask) | (i_wdata & i_wmask);
    end
  end

  // bus not driven between requests shows a moving pattern, not stale data
  assign o_rdata = i_req ? mem[i_addr] : idle_pat;
endmodule

// *** dv/io_space_access_twi_regs_tb.sv ***
`timescale 1ns/1ns
module io_space_access_twi_regs_tb;
  import iosa_pkg::*;
  logic        i_mclk, i_nrst, i_acc_valid, i_evt_set, i_wcol_set, i_stop_done, i_state_we, i_rx_we;
  iosa_kind_t  i_acc_kind;
  logic [15:0] i_acc_addr;
  logic [2:0]  i_acc_bit;
  logic [7:0]  i_acc_wdata, i_rx_data, i_io_rdata, o_acc_rdata_q, o_io_addr_q, o_io_wdata_q, o_io_wmask_q;
  logic        o_acc_done_q, o_acc_err_q, o_acc_bit_q, o_acc_skip_q, o_io_req_q, o_io_we_q;
  logic        o_evt_flag_q, o_ack_en_q, o_start_req_q, o_stop_req_q, o_wcol_flag_q, o_iface_en_q, o_irq_en_q;
  logic        o_gc_accept_q;
  logic [6:0]  o_own_addr_q;
  logic [1:0]  o_prescale_q;
  logic [4:0]  i_state_code, m_code;
  logic [7:0]  o_bitrate_q, o_tx_data_q, m_br, m_own, m_data, m_ctrl, mem_m [256];
  logic [1:0]  m_ps;
  logic [31:0] seed = 32'hc7be750a;
  logic [15:0] at [9] = '{16'h0000, 16'h001f, 16'h0020, 16'h003f, 16'h0040, 16'h005f, 16'h0060, 16'h00ff, 16'h0100};
  int          error_cnt = 0;
  int          check_count = 0;

  iosa_twi_regs u_dut (.i_mclk, .i_nrst, .i_acc_valid, .i_acc_kind, .i_acc_addr, .i_acc_bit, .i_acc_wdata,
    .o_acc_done_q, .o_acc_err_q, .o_acc_rdata_q, .o_acc_bit_q, .o_acc_skip_q, .o_io_req_q, .o_io_we_q,
    .o_io_addr_q, .o_io_wdata_q, .o_io_wmask_q, .i_io_rdata, .i_evt_set, .i_wcol_set, .i_stop_done,
    .i_state_we, .i_state_code, .i_rx_we, .i_rx_data, .o_evt_flag_q, .o_ack_en_q, .o_start_req_q,
    .o_stop_req_q, .o_wcol_flag_q, .o_iface_en_q, .o_irq_en_q, .o_own_addr_q, .o_gc_accept_q,
    .o_prescale_q, .o_bitrate_q, .o_tx_data_q);
  iosa_periph_model u_periph (.i_mclk(i_mclk), .i_req(o_io_req_q), .i_we(o_io_we_q), .i_addr(o_io_addr_q),
    .i_wdata(o_io_wdata_q), .i_wmask(o_io_wmask_q), .o_rdata(i_io_rdata));

  // 50 mhz core clock
  initial begin
    i_mclk = 0;
    forever #10 i_mclk = ~i_mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // expected view of the serial group
  function automatic logic [7:0] grp_rd(input logic [7:0] da);
    case (da)
      ADR_BITRATE: return m_br;
      ADR_STATE:   return {m_code, 1'b0, m_ps};
      ADR_OWNADR:  return m_own;
      ADR_DATA:    return m_data;
      ADR_CTRL:    return m_ctrl;
      default:     return 8'h00;
    endcase
  endfunction

  task automatic chk_regs();
    chk({o_evt_flag_q, o_ack_en_q, o_start_req_q, o_stop_req_q, o_wcol_flag_q, o_iface_en_q, 1'b0, o_irq_en_q},
      m_ctrl);
    chk({o_own_addr_q, o_gc_accept_q}, m_own);
    chk(o_prescale_q, m_ps);
    chk(o_bitrate_q, m_br);
    chk(o_tx_data_q, m_data);
  endtask

  // one core access, entered just after an edge; answer polled under a bound
  task automatic acc(input iosa_kind_t k, input logic [15:0] a, input logic [2:0] b, input logic [7:0] w);
    logic       bf, pf, e, wr, fw, got, fs;
    logic [7:0] da, mk, fd, rv;
    bf = k inside {KIND_SET_BIT, KIND_CLR_BIT, KIND_SKIP_SET, KIND_SKIP_CLR};
    pf = k inside {KIND_PORT_READ, KIND_PORT_WRITE};
    e = bf ? a > IO_BIT_MAX : pf ? a > IO_PORT_MAX : (a < IO_DS_OFS || a > IO_DS_HI);
    da = (bf || pf) ? 8'(a + IO_DS_OFS) : a[7:0];
    wr = k inside {KIND_PORT_WRITE, KIND_STORE, KIND_SET_BIT, KIND_CLR_BIT};
    fw = !e && (da < GRP_LO || da > GRP_HI);
    mk = (k == KIND_SET_BIT || k == KIND_CLR_BIT) ? 8'h01 << b : 8'hff;
    fd = k == KIND_SET_BIT ? 8'hff : k == KIND_CLR_BIT ? 8'h00 : w;
    rv = (e || wr) ? 8'h00 : fw ? mem_m[da] : grp_rd(da);
    got = 0;
    fs = 0;
    i_acc_valid = 1;
    i_acc_kind = k;
    i_acc_addr = a;
    i_acc_bit = b;
    i_acc_wdata = w;
    @(posedge i_mclk);
    #1;
    i_acc_valid = 0;
    repeat (4) begin
      if (!got) begin
        #8;
        if (o_io_req_q === 1'b1) begin
          fs = 1;
          chk(o_io_addr_q, da);
          chk(o_io_we_q, wr);
          chk(o_io_wmask_q, mk);
          if (wr) chk(o_io_wdata_q, fd);
        end
        if (o_acc_done_q === 1'b1) begin
          got = 1;
          chk(o_acc_err_q, e);
          chk(o_acc_rdata_q, rv);
          chk(o_acc_bit_q, rv[b]);
          chk(o_acc_skip_q, e ? 1'b0 : k == KIND_SKIP_SET ? rv[b] : k == KIND_SKIP_CLR ? !rv[b] : 1'b0);
        end
        @(posedge i_mclk);
        #1;
      end
    end
    chk(got, 1'b1);
    chk(fs, fw);
    if (fw && wr) mem_m[da] = (mem_m[da] & ~mk) | (fd & mk);
    if (!e && !fw && wr) begin
      case (da)
        ADR_BITRATE: m_br = w;
        ADR_STATE:   m_ps = w[1:0];
        ADR_OWNADR:  m_own = w;
        ADR_DATA: begin
          if (m_ctrl[CB_EVT]) m_ctrl[CB_WCOL] = 1'b0;
          m_data = w;
        end
        ADR_CTRL:    m_ctrl = {m_ctrl[7] & ~w[7], w[6:4], m_ctrl[3], w[2], 1'b0, w[0]};
        default:     ;
      endcase
    end
    chk_regs();
  endtask

  // one cycle of bus engine events
  task automatic eng(input logic ev, wc, sd, sw, input logic [4:0] c, input logic rw, input logic [7:0] rx);
    i_evt_set = ev;
    i_wcol_set = wc;
    i_stop_done = sd;
    i_state_we = sw;
    i_state_code = c;
    i_rx_we = rw;
    i_rx_data = rx;
    @(posedge i_mclk);
    #1;
    {i_evt_set, i_wcol_set, i_stop_done, i_state_we, i_rx_we} = 5'h00;
    if (ev) m_ctrl[CB_EVT] = 1'b1;
    if (wc) m_ctrl[CB_WCOL] = 1'b1;
    if (sd) m_ctrl[CB_STO] = 1'b0;
    if (sw) m_code = c;
    if (rw) m_data = rx;
    @(posedge i_mclk);
    #1;
    chk_regs();
  endtask

  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #600000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] a;
    logic [7:0]  w;
    logic        got;
    {i_nrst, i_acc_valid, i_evt_set, i_wcol_set, i_stop_done, i_state_we, i_rx_we} = 7'h00;
    i_acc_kind = KIND_LOAD;
    i_acc_addr = 16'h0000;
    i_acc_bit = 3'h0;
    {i_acc_wdata, i_rx_data, i_state_code} = 21'h0;
    {m_br, m_own, m_data, m_ctrl, m_code, m_ps} = 39'h0;
    for (int i = 0; i < 256; i++) mem_m[i] = 8'(i * 7 + 3);
    repeat (8) @(posedge i_mclk);
    #1;
    i_nrst = 1;
    @(posedge i_mclk);
    #1;
    chk_regs();
    // whole group written with ones, then read back, reserved places included
    for (int i = GRP_LO; i <= GRP_HI; i++) acc(KIND_STORE, 16'(i), 3'h0, 8'hff);
    for (int i = GRP_LO; i <= GRP_HI; i++) acc(KIND_LOAD, 16'(i), 3'h0, 8'h00);
    // write then read on the very next cycle
    i_acc_valid = 1;
    i_acc_kind = KIND_STORE;
    i_acc_addr = 16'h00bb;
    i_acc_wdata = 8'h3c;
    @(posedge i_mclk);
    #1;
    i_acc_kind = KIND_LOAD;
    @(posedge i_mclk);
    #1;
    i_acc_valid = 0;
    got = 0;
    repeat (3) begin
      if (!got) begin
        #8;
        got = o_acc_done_q === 1'b1;
        @(posedge i_mclk);
        #1;
      end
    end
    chk(o_acc_done_q, 1'b1);
    chk(o_acc_rdata_q, 8'h3c);
    m_data = 8'h3c;
    @(posedge i_mclk);
    #1;
    // flags from the engine, zero writes keep them, a data write clears collision, a one write clears event
    eng(1, 1, 0, 1, 5'h15, 1, 8'ha5);
    acc(KIND_LOAD, 16'h00b9, 3'h3, 8'h00);
    acc(KIND_STORE, 16'h00bc, 3'h0, 8'h45);
    acc(KIND_STORE, 16'h00bb, 3'h0, 8'h96);
    acc(KIND_STORE, 16'h00bc, 3'h0, 8'hd5);
    eng(0, 0, 1, 0, 5'h00, 0, 8'h00);
    // every form at every range boundary
    for (int k = 0; k < 8; k++) begin
      foreach (at[j]) acc(iosa_kind_t'(k), at[j], 3'(rnd()), 8'(rnd()));
    end
    // random traffic with engine events mixed in
    repeat (400) begin
      r = rnd();
      a = r[25] ? {10'h0, r[21:16]} : {7'h0, r[24:16]};
      w = r[7:0];
      if (a[7:0] == ADR_CTRL) w[1] = 1'b0;
      if (a[7:0] == ADR_STATE) w[2] = 1'b0;
      if (r[26]) eng(r[27], r[28], r[29], r[30], r[12:8], r[31], r[15:8]);
      acc(iosa_kind_t'(r[10:8]), a, r[13:11], w);
    end
    print_verdict();
  end
endmodule
